// ### shared/sfdp_map_pkg.sv
// Constants and types shared by the protection-bit map decoder
package sfdp_map_pkg;
    localparam int SEC_NUM = 5;
    localparam logic [7:0] TYPE_4K = 8'h01;
    localparam logic [7:0] TYPE_8K = 8'h02;
    localparam logic [7:0] TYPE_32K = 8'h03;
    localparam logic [7:0] TYPE_64K = 8'h04;
    localparam logic [7:0] TYPE_LOC_BASE = 8'h4c;
    localparam logic [7:0] TYPE_LOC_STEP = 8'h02;
    localparam int SHIFT_8K = 13;
    localparam int SHIFT_32K = 15;
    localparam int SHIFT_64K = 16;
    localparam logic [7:0] ADD_ZERO = 8'h00;
    localparam logic [7:0] ADD_BOT8_START = 8'hff;
    localparam logic [7:0] ADD_BOT8_END = 8'h06;
    localparam logic [7:0] ADD_LO32 = 8'hfd;
    localparam logic [7:0] ADD_64_END = 8'hfc;
    localparam logic [7:0] ADD_HI32 = 8'hfe;
    localparam logic [7:0] ADD_TOP8_START = 8'h07;
    localparam logic [7:0] ADD_TOP8_END = 8'h0e;
    localparam logic [7:0] CNT_8K_LOG = 8'h02;
    localparam logic [7:0] CNT_32K_LOG = 8'h00;
    localparam logic [3:0] M_MIN = 4'h4;
    localparam logic [3:0] M_MAX = 4'h8;
    localparam logic [1:0] FLD_TYPE = 2'h0;
    localparam logic [1:0] FLD_COUNT = 2'h1;
    localparam logic [1:0] FLD_START = 2'h2;
    localparam logic [1:0] FLD_END = 2'h3;
    typedef enum logic [1:0] {S_IDLE, S_SCAN} scan_st_t;
endpackage

// ### logic/sfdp_protect_bit_map_decoder.sv
// Section table store, default table source and block-to-bit query walker
`timescale 1ns/10ps
module sfdp_protect_bit_map_decoder
    import sfdp_map_pkg::*;
(
    input wire logic mclk_i,              // 100 MHz clock
    input wire logic resetn_i,            // Async reset, active low
    input wire logic [3:0] density_m_i,   // Density constant m, 4..8
    input wire logic load_default_i,      // Pulse: load own table for m
    input wire logic sec_wr_i,            // Pulse: write one section entry
    input wire logic [2:0] sec_idx_i,     // Section written, 0..4
    input wire logic [7:0] type_field_i,  // Sector type byte
    input wire logic [7:0] count_field_i, // Number of sectors byte
    input wire logic [7:0] protect_bit_start_field_i, // Start adder byte
    input wire logic [7:0] protect_bit_end_field_i,   // End adder byte
    input wire logic [2:0] tbl_sec_i,     // Default table read: section
    input wire logic [1:0] tbl_fld_i,     // Default table read: field
    input wire logic query_i,             // Pulse: look up block_idx_i
    input wire logic [8:0] block_idx_i,   // Block index from address zero
    output logic tbl_byte_valid_o,        // Default table byte is valid
    output logic [7:0] tbl_byte_o,        // Default table byte
    output logic [7:0] type_loc_o,        // Size entry location of section
    output logic loaded_o,                // All sections written
    output logic busy_o,                  // Query walk in progress
    output logic ans_valid_o,             // Pulse: answer ready
    output logic ans_err_o,               // Answer is an error
    output logic [23:0] blk_size_o,       // Block size in bytes
    output logic [23:0] blk_base_o,       // Block base address
    output logic [8:0] wr_bit_o,          // Write-lock bit position
    output logic [8:0] rd_bit_o,          // Read-lock bit position
    output logic rd_bit_en_o              // Block has a read-lock bit
);
    typedef struct packed {
        scan_st_t st;
        logic [SEC_NUM-1:0][7:0] typ;
        logic [SEC_NUM-1:0][7:0] cnt;
        logic [SEC_NUM-1:0][7:0] bps;
        logic [SEC_NUM-1:0][7:0] bpe;
        logic [SEC_NUM-1:0] ld;
        logic [2:0] sec;
        logic [8:0] rem;
        logic [23:0] acc;
        logic tv;
        logic [7:0] tb;
        logic [7:0] tloc;
        logic av;
        logic ae;
        logic [23:0] sz;
        logic [23:0] ba;
        logic [8:0] wb;
        logic [8:0] rb;
        logic re;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    // Two to the m
    function automatic logic [8:0] pow2m(input logic [3:0] m);
        pow2m = 9'h001 << m;
    endfunction

    // Block count of a section
    function automatic logic [8:0] blk_count(input logic [7:0] t, input logic [7:0] n,
                                             input logic [3:0] m);
        blk_count = 9'h000;
        if (t == TYPE_64K) begin
            blk_count = pow2m(m) - 9'h002;
        end else if (t == TYPE_8K || t == TYPE_32K) begin
            if (n < 8'h09) begin
                blk_count = 9'h001 << n[3:0];
            end
        end
    endfunction

    // Size of one block as a shift of one byte
    function automatic logic [4:0] size_shift(input logic [7:0] t);
        case (t)
            TYPE_8K: size_shift = 5'(SHIFT_8K);
            TYPE_32K: size_shift = 5'(SHIFT_32K);
            TYPE_64K: size_shift = 5'(SHIFT_64K);
            default: size_shift = 5'h00;
        endcase
    endfunction

    // Adder byte to protection bit position
    function automatic logic [8:0] bit_pos(input logic [7:0] c, input logic [3:0] m);
        if (c == ADD_ZERO) begin
            bit_pos = 9'h000;
        end else begin
            bit_pos = pow2m(m) + 9'h001 + {c[7], c};
        end
    endfunction

    // The device's own section table for density m
    function automatic logic [7:0] dflt(input logic [2:0] sc, input logic [1:0] f,
                                        input logic [3:0] m);
        logic [7:0] t;
        logic [7:0] n;
        logic [7:0] a;
        logic [7:0] b;
        t = TYPE_8K;
        n = CNT_8K_LOG;
        a = ADD_BOT8_START;
        b = ADD_BOT8_END;
        case (sc)
            3'h1: begin
                t = TYPE_32K;
                n = CNT_32K_LOG;
                a = ADD_LO32;
                b = ADD_LO32;
            end
            3'h2: begin
                t = TYPE_64K;
                n = {4'h0, m};
                a = ADD_ZERO;
                b = ADD_64_END;
            end
            3'h3: begin
                t = TYPE_32K;
                n = CNT_32K_LOG;
                a = ADD_HI32;
                b = ADD_HI32;
            end
            3'h4: begin
                a = ADD_TOP8_START;
                b = ADD_TOP8_END;
            end
            default: begin
            end
        endcase
        case (f)
            FLD_TYPE: dflt = t;
            FLD_COUNT: dflt = n;
            FLD_START: dflt = a;
            default: dflt = b;
        endcase
    endfunction

    logic m_ok;
    logic [7:0] cur_t;
    logic [8:0] cur_n;
    logic [4:0] cur_sh;
    logic [8:0] cur_bit;

    // Range check on m and the current section of the walk
    always_comb begin
        m_ok = (density_m_i >= M_MIN) && (density_m_i <= M_MAX);
        cur_t = s_r.typ[s_r.sec];
        cur_n = blk_count(cur_t, s_r.cnt[s_r.sec], density_m_i);
        cur_sh = size_shift(cur_t);
        cur_bit = bit_pos(s_r.bps[s_r.sec], density_m_i);
    end

    // Next-state logic
    always_comb begin
        s_nxt = s_r;
        s_nxt.av = 1'b0;
        // Default table read port
        s_nxt.tv = m_ok && (tbl_sec_i < 3'(SEC_NUM));
        s_nxt.tb = dflt(tbl_sec_i, tbl_fld_i, density_m_i);
        s_nxt.tloc = TYPE_LOC_BASE + TYPE_LOC_STEP * (s_nxt.tb - TYPE_4K);
        if (tbl_fld_i != FLD_TYPE) begin
            s_nxt.tloc = TYPE_LOC_BASE + TYPE_LOC_STEP * (dflt(tbl_sec_i, FLD_TYPE,
                         density_m_i) - TYPE_4K);
        end
        // Table loading, blocked while a walk runs
        if (s_r.st == S_IDLE) begin
            if (load_default_i && m_ok) begin
                for (int i = 0; i < SEC_NUM; i++) begin
                    s_nxt.typ[i] = dflt(3'(i), FLD_TYPE, density_m_i);
                    s_nxt.cnt[i] = dflt(3'(i), FLD_COUNT, density_m_i);
                    s_nxt.bps[i] = dflt(3'(i), FLD_START, density_m_i);
                    s_nxt.bpe[i] = dflt(3'(i), FLD_END, density_m_i);
                end
                s_nxt.ld = '1;
            end else if (sec_wr_i && sec_idx_i < 3'(SEC_NUM)) begin
                s_nxt.typ[sec_idx_i] = type_field_i;
                s_nxt.cnt[sec_idx_i] = count_field_i;
                s_nxt.bps[sec_idx_i] = protect_bit_start_field_i;
                s_nxt.bpe[sec_idx_i] = protect_bit_end_field_i;
                s_nxt.ld[sec_idx_i] = 1'b1;
            end
        end
        case (s_r.st)
            S_IDLE: begin
                if (query_i && !load_default_i && !sec_wr_i) begin
                    if (&s_r.ld && m_ok) begin
                        s_nxt.st = S_SCAN;
                        s_nxt.sec = 3'h0;
                        s_nxt.rem = block_idx_i;
                        s_nxt.acc = 24'h000000;
                    end else begin
                        s_nxt.av = 1'b1;
                        s_nxt.ae = 1'b1;
                    end
                end
            end
            S_SCAN: begin
                // Each section is walked on its own even if its size recurs
                if (cur_sh == 5'h00 || cur_n == 9'h000) begin
                    s_nxt.st = S_IDLE;
                    s_nxt.av = 1'b1;
                    s_nxt.ae = 1'b1;
                end else if (s_r.rem < cur_n) begin
                    s_nxt.st = S_IDLE;
                    s_nxt.av = 1'b1;
                    s_nxt.ae = 1'b0;
                    s_nxt.sz = 24'h000001 << cur_sh;
                    s_nxt.ba = s_r.acc + (24'(s_r.rem) << cur_sh);
                    if (cur_t == TYPE_8K) begin
                        // Two bits per block: even one write lock, odd one read lock
                        s_nxt.wb = cur_bit + {s_r.rem[7:0], 1'b0};
                        s_nxt.rb = s_nxt.wb + 9'h001;
                        if (s_nxt.wb[0]) begin
                            s_nxt.rb = s_nxt.wb;
                            s_nxt.wb = s_nxt.wb + 9'h001;
                        end
                        s_nxt.re = 1'b1;
                    end else begin
                        s_nxt.wb = cur_bit + s_r.rem;
                        s_nxt.rb = 9'h000;
                        s_nxt.re = 1'b0;
                    end
                end else begin
                    s_nxt.rem = s_r.rem - cur_n;
                    s_nxt.acc = s_r.acc + 24'({cur_n, 16'h0000} >> (5'(16) - cur_sh));
                    s_nxt.sec = s_r.sec + 3'h1;
                    if (s_r.sec == 3'(SEC_NUM - 1)) begin
                        s_nxt.st = S_IDLE;
                        s_nxt.av = 1'b1;
                        s_nxt.ae = 1'b1;
                    end
                end
            end
            default: begin
                s_nxt.st = S_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // Outputs
    assign tbl_byte_valid_o = s_r.tv;
    assign tbl_byte_o = s_r.tb;
    assign type_loc_o = s_r.tloc;
    assign loaded_o = &s_r.ld;
    assign busy_o = (s_r.st == S_SCAN);
    assign ans_valid_o = s_r.av;
    assign ans_err_o = s_r.ae;
    assign blk_size_o = s_r.sz;
    assign blk_base_o = s_r.ba;
    assign wr_bit_o = s_r.wb;
    assign rd_bit_o = s_r.rb;
    assign rd_bit_en_o = s_r.re;
endmodule

// ### verification/sfdp_map_props.sv
// Port-level checker for the protection-bit map decoder
`timescale 1ns/10ps
module sfdp_map_props
    import sfdp_map_pkg::*;
(
    input wire logic mclk_i,            // Clock
    input wire logic resetn_i,          // Reset, active low
    input wire logic [3:0] density_m_i, // Density constant
    input wire logic load_default_i,    // Default load strobe
    input wire logic sec_wr_i,          // Section write strobe
    input wire logic query_i,           // Query strobe
    input wire logic tbl_byte_valid_o,  // Table byte valid
    input wire logic [7:0] type_loc_o,  // Size entry location
    input wire logic loaded_o,          // Table complete
    input wire logic busy_o,            // Walk running
    input wire logic ans_valid_o,       // Answer strobe
    input wire logic ans_err_o,         // Answer error
    input wire logic [23:0] blk_size_o, // Block size
    input wire logic [23:0] blk_base_o, // Block base
    input wire logic [8:0] wr_bit_o,    // Write-lock bit
    input wire logic [8:0] rd_bit_o,    // Read-lock bit
    input wire logic rd_bit_en_o        // Read-lock present
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!resetn_i);
    // A query is taken only when idle and no table write competes with it
    wire logic take = query_i && !busy_o && !load_default_i && !sec_wr_i;
    wire logic good = ans_valid_o && !ans_err_o;

    // Answer timing and table state
    a_err_unloaded: assert property (take && !loaded_o |=> ans_valid_o && ans_err_o)
        else $error("query without table gave no error answer");
    a_ans_within: assert property (take && loaded_o && density_m_i inside {[M_MIN:M_MAX]}
        |-> ##[2:6] ans_valid_o)
        else $error("answer missing after query");
    // An error answer may follow at once when a new query is taken in the answer cycle
    a_ans_pulse: assert property (ans_valid_o && !take |=> !ans_valid_o)
        else $error("answer strobe longer than one cycle");
    a_busy_walk: assert property (take && loaded_o && density_m_i inside {[M_MIN:M_MAX]}
        |=> busy_o)
        else $error("walk did not start after a taken query");
    a_loaded_holds: assert property (loaded_o |=> loaded_o)
        else $error("table lost without reset");
    a_data_held: assert property (!good |-> $stable({blk_size_o, blk_base_o, wr_bit_o,
        rd_bit_o, rd_bit_en_o}))
        else $error("answer data moved without a good answer");
    // Decoded contents
    a_type_loc: assert property (tbl_byte_valid_o |-> type_loc_o inside {8'h4e, 8'h50, 8'h52})
        else $error("size entry location out of set");
    a_eight_pair: assert property (good && rd_bit_en_o
        |-> rd_bit_o == wr_bit_o + 9'h001 && blk_size_o == 24'h002000 && !wr_bit_o[0])
        else $error("small block lock pair wrong");
    a_big_single: assert property (good && !rd_bit_en_o
        |-> rd_bit_o == 9'h000 && blk_size_o inside {24'h008000, 24'h010000})
        else $error("large block size or read bit wrong");
    a_base_align: assert property (good |-> (blk_base_o & (blk_size_o - 24'h000001)) == 24'h0)
        else $error("block base not aligned to its size");
    a_big_bits: assert property (good && blk_size_o == 24'h010000
        |-> int'(wr_bit_o) <= (1 << density_m_i) - 3)
        else $error("large block bit beyond end location");
    c_err: cover property (ans_valid_o && ans_err_o);
    c_small: cover property (good && rd_bit_en_o);
    c_mid: cover property (good && blk_size_o == 24'h008000);
endmodule

// ### verification/host_loader_model.sv
// Host controller model that writes section entries into the decoder
`timescale 1ns/10ps
module host_loader_model (
    input wire logic mclk_i,      // Decoder clock
    output logic sec_wr_o,        // Section write strobe
    output logic [2:0] sec_idx_o, // Section index
    output logic [31:0] fields_o  // Type, count, start, end bytes
);
    // Sections from address zero: 8K, 32K, 64K run, 32K, 8K
    logic [31:0] tbl [5] = '{32'h0202ff06, 32'h0300fdfd, 32'h040500fc,
        32'h0300fefe, 32'h0202070e};
    initial begin
        sec_wr_o = 1'b0;
        sec_idx_o = 3'h0;
        fields_o = 32'h0;
    end
    // One whole section per strobe; bytes scrambled once released
    task automatic put(input logic [2:0] idx, input logic [31:0] val);
        @(negedge mclk_i);
        sec_wr_o = 1'b1;
        sec_idx_o = idx;
        fields_o = val;
        @(negedge mclk_i);
        sec_wr_o = 1'b0;
        fields_o = ~val;
    endtask
    // Writes the table upward from address zero, strobes gap+2 cycles apart
    task automatic load_all(input int gap);
        for (int i = 0; i < 5; i++) begin
            put(i[2:0], tbl[i]);
            repeat (gap) @(negedge mclk_i);
        end
    endtask
endmodule

// ### verification/sfdp_protect_bit_map_decoder_tb.sv
// Testbench for the protection-bit map decoder
`timescale 1ns/10ps
module sfdp_protect_bit_map_decoder_tb;
    import sfdp_map_pkg::*;
    typedef struct packed {
        logic [8:0] idx;
        logic [23:0] size;
        logic [23:0] base;
        logic [8:0] wr;
        logic [8:0] rd;
        logic en;
    } row_t;
    logic mclk_i, resetn_i, load_default_i, query_i, sec_wr_i, tbl_byte_valid_o, loaded_o;
    logic busy_o, ans_valid_o, ans_err_o, rd_bit_en_o;
    logic [3:0] density_m_i;
    logic [2:0] sec_idx_i, tbl_sec_i;
    logic [1:0] tbl_fld_i;
    logic [31:0] fld;
    logic [8:0] block_idx_i, wr_bit_o, rd_bit_o;
    logic [7:0] tbl_byte_o, type_loc_o;
    logic [23:0] blk_size_o, blk_base_o;
    int error_cnt = 0;
    int total_checks = 0;
    // Expected default table for m = 5, section 0 first
    logic [159:0] def_tbl = 160'h0202ff06_0300fdfd_040500fc_0300fefe_0202070e;
    // Block index against size, base, write bit, read bit, read enable (m = 5)
    row_t rows [8] = '{
        '{9'h000, 24'h002000, 24'h000000, 9'h020, 9'h021, 1'b1},
        '{9'h003, 24'h002000, 24'h006000, 9'h026, 9'h027, 1'b1},
        '{9'h004, 24'h008000, 24'h008000, 9'h01e, 9'h000, 1'b0},
        '{9'h005, 24'h010000, 24'h010000, 9'h000, 9'h000, 1'b0},
        '{9'h022, 24'h010000, 24'h1e0000, 9'h01d, 9'h000, 1'b0},
        '{9'h023, 24'h008000, 24'h1f0000, 9'h01f, 9'h000, 1'b0},
        '{9'h024, 24'h002000, 24'h1f8000, 9'h028, 9'h029, 1'b1},
        '{9'h027, 24'h002000, 24'h1fe000, 9'h02e, 9'h02f, 1'b1}};

    sfdp_protect_bit_map_decoder sfdp_protect_bit_map_decoder_i (.mclk_i(mclk_i),
        .resetn_i(resetn_i), .density_m_i(density_m_i), .load_default_i(load_default_i),
        .sec_wr_i(sec_wr_i), .sec_idx_i(sec_idx_i), .type_field_i(fld[31:24]),
        .count_field_i(fld[23:16]), .protect_bit_start_field_i(fld[15:8]),
        .protect_bit_end_field_i(fld[7:0]), .tbl_sec_i(tbl_sec_i), .tbl_fld_i(tbl_fld_i),
        .query_i(query_i), .block_idx_i(block_idx_i), .tbl_byte_valid_o(tbl_byte_valid_o),
        .tbl_byte_o(tbl_byte_o), .type_loc_o(type_loc_o), .loaded_o(loaded_o),
        .busy_o(busy_o), .ans_valid_o(ans_valid_o), .ans_err_o(ans_err_o),
        .blk_size_o(blk_size_o), .blk_base_o(blk_base_o), .wr_bit_o(wr_bit_o),
        .rd_bit_o(rd_bit_o), .rd_bit_en_o(rd_bit_en_o));
    host_loader_model host_loader_model_i (.mclk_i(mclk_i), .sec_wr_o(sec_wr_i),
        .sec_idx_o(sec_idx_i), .fields_o(fld));

    // Clock at 100 MHz
    initial begin
        mclk_i = 1'b0;
        forever #5 mclk_i = ~mclk_i;
    end
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        total_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Pulse a query and watch every edge from the taking one for the answer strobe
    task automatic ask(input logic [8:0] idx, input logic err);
        @(negedge mclk_i);
        query_i = 1'b1;
        block_idx_i = idx;
        for (int n = 0; n < 8; n++) begin
            @(posedge mclk_i);
            #1;
            if (ans_valid_o === 1'b1) break;
            @(negedge mclk_i);
            query_i = 1'b0;
        end
        chk(ans_valid_o, 1'b1);
        chk(ans_err_o, err);
        // Drop the query before the next edge so it is not taken twice
        @(negedge mclk_i);
        query_i = 1'b0;
    endtask
    task automatic chk_ans(input row_t r);
        ask(r.idx, 1'b0);
        chk(blk_size_o, r.size);
        chk(blk_base_o, r.base);
        chk(wr_bit_o, r.wr);
        chk(rd_bit_o, r.rd);
        chk(rd_bit_en_o, r.en);
    endtask
    task automatic pulse_default();
        @(negedge mclk_i);
        load_default_i = 1'b1;
        @(negedge mclk_i);
        load_default_i = 1'b0;
    endtask
    initial begin
        #200000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        density_m_i = 4'h5;
        load_default_i = 1'b0;
        query_i = 1'b0;
        block_idx_i = 9'h000;
        tbl_sec_i = 3'h0;
        tbl_fld_i = 2'h0;
        resetn_i = 1'b0;
        repeat (12) @(negedge mclk_i);
        chk(loaded_o, 1'b0);
        chk(ans_valid_o, 1'b0);
        resetn_i = 1'b1;
        ask(9'h000, 1'b1);
        host_loader_model_i.load_all(2);
        @(negedge mclk_i);
        chk(loaded_o, 1'b1);
        foreach (rows[i]) chk_ans(rows[i]);
        // Own table: every byte and its size entry location
        pulse_default();
        for (int k = 0; k < 20; k++) begin
            tbl_sec_i = 3'(k / 4);
            tbl_fld_i = 2'(k % 4);
            @(negedge mclk_i);
            chk(tbl_byte_o, def_tbl[159 - 8 * k -: 8]);
            chk(tbl_byte_valid_o, 1'b1);
            if (k % 4 == 0) chk(type_loc_o, 8'h4a + 8'h02 * def_tbl[159 - 8 * k -: 8]);
        end
        foreach (rows[i]) chk_ans(rows[i]);
        ask(9'h028, 1'b1);
        // Start byte of zero means bit zero itself
        host_loader_model_i.put(3'h0, 32'h02020006);
        chk_ans('{9'h001, 24'h002000, 24'h002000, 9'h002, 9'h003, 1'b1});
        // Smallest density: 14 large blocks, upper 32K bit 15, top bits from 24
        density_m_i = 4'h4;
        pulse_default();
        chk_ans('{9'h013, 24'h008000, 24'h0f0000, 9'h00f, 9'h000, 1'b0});
        chk_ans('{9'h017, 24'h002000, 24'h0fe000, 9'h01e, 9'h01f, 1'b1});
        ask(9'h018, 1'b1);
        // A density outside 4..8 refuses every query
        density_m_i = 4'h9;
        ask(9'h000, 1'b1);
        wrap_up();
    end
endmodule
bind sfdp_protect_bit_map_decoder sfdp_map_props sfdp_map_props_i (.mclk_i(mclk_i),
    .resetn_i(resetn_i), .density_m_i(density_m_i), .load_default_i(load_default_i),
    .sec_wr_i(sec_wr_i), .query_i(query_i), .tbl_byte_valid_o(tbl_byte_valid_o),
    .type_loc_o(type_loc_o), .loaded_o(loaded_o), .busy_o(busy_o),
    .ans_valid_o(ans_valid_o), .ans_err_o(ans_err_o), .blk_size_o(blk_size_o),
    .blk_base_o(blk_base_o), .wr_bit_o(wr_bit_o), .rd_bit_o(rd_bit_o),
    .rd_bit_en_o(rd_bit_en_o));
